// ===== design/nsio_pkg.sv
// package: constants and carrier types for the supervisor io ports
package nsio_pkg;
    // can controller byte registers on the external bus
    localparam logic [15:0] CAN_CONTROL       = 16'h8000;
    localparam logic [15:0] CAN_COMMAND       = 16'h8001;
    localparam logic [15:0] CAN_STATUS        = 16'h8002;
    localparam logic [15:0] CAN_IRQ_FLAGS     = 16'h8003;
    localparam logic [15:0] CAN_ACCEPT_CODE   = 16'h8004;
    localparam logic [15:0] CAN_ACCEPT_MASK   = 16'h8005;
    localparam logic [15:0] CAN_BIT_TIMING_1  = 16'h8006;
    localparam logic [15:0] CAN_BIT_TIMING_2  = 16'h8007;
    localparam logic [15:0] CAN_DRIVER_CONFIG = 16'h8008;
    localparam logic [15:0] CAN_TEST          = 16'h8009;
    localparam logic [15:0] CAN_TX_FIRST      = 16'h800a;
    localparam logic [15:0] CAN_TX_LAST       = 16'h8013;
    localparam logic [15:0] CAN_RX_FIRST      = 16'h8014;
    localparam logic [15:0] CAN_RX_LAST       = 16'h801d;
    localparam logic [15:0] CAN_SPARE         = 16'h801e;
    localparam logic [15:0] CAN_CLOCK_DIVIDER = 16'h801f;
    localparam logic [7:0]  CAN_SPAN_LAST     = 8'h1f;

    // on-chip port and control registers
    localparam logic [15:0] PORT_ONE_DIRECTION   = 16'hfe80;
    localparam logic [15:0] PORT_ONE_DATA        = 16'hfe81;
    localparam logic [15:0] SYSTEM_CONTROL_ONE   = 16'hfe82;
    localparam logic [15:0] PORT_FIVE_DIRECTION  = 16'hfe83;
    localparam logic [15:0] PORT_FIVE_DATA       = 16'hfe84;
    localparam logic [15:0] PORT_SIX_DIRECTION   = 16'hfe85;
    localparam logic [15:0] PORT_SIX_DATA        = 16'hfe86;
    localparam logic [15:0] PORT_SEVEN_DIRECTION = 16'hfe87;
    localparam logic [15:0] PORT_SEVEN_DATA      = 16'hfe88;
    localparam logic [15:0] PORT_EIGHT_DATA      = 16'hfe89;
    localparam logic [15:0] PORT_NINE_DIRECTION  = 16'hfe8a;
    localparam logic [15:0] PORT_NINE_DATA       = 16'hfe8b;
    localparam logic [15:0] SYSTEM_CONTROL_TWO   = 16'hfe8c;
    localparam logic [15:0] TIMER_PIN_CONFIG     = 16'hfe8d;
    localparam logic [15:0] BYTE_TIMER_CONTROL   = 16'hfe8e;
    localparam logic [15:0] TIMER1_CAPTURE       = 16'hfe8f;
    localparam logic [15:0] TIMER2_CAPTURE       = 16'hfe90;
    localparam logic [15:0] XFER_DATA            = 16'hfe91;
    localparam logic [15:0] XFER_STATUS          = 16'hfe92;

    // reset values
    localparam logic [7:0] P1_DIR_RST  = 8'h01;
    localparam logic [7:0] SC1_RST     = 8'h20;
    localparam logic [7:0] P5_DIR_RST  = 8'hff;
    localparam logic [7:0] P6_DIR_RST  = 8'h0e;
    localparam logic [7:0] P6_DATA_RST = 8'h0e;
    localparam logic [7:0] INPUT_DIR   = 8'h00;

    // field positions and codes
    localparam int         SC1_IRQ_EN     = 5;
    localparam int         SC2_PIN_FN_MSB = 1;
    localparam int         BT_CCLR_LSB    = 3;
    localparam logic [2:0] BT_CKS_PIN     = 3'h7;
    localparam int         XFER_DONE_BIT  = 0;

    // timing
    localparam int         MCLK_HZ     = 100_000_000;
    localparam int         PHI_HZ      = 10_000_000;
    localparam int         PHI_DIV     = MCLK_HZ / PHI_HZ;
    localparam logic [3:0] PHI_LAST    = 4'(PHI_DIV - 1);
    localparam logic [3:0] PHI_HALF    = 4'(PHI_DIV / 2);
    localparam int         WAIT_STATES = 2;
    localparam logic [1:0] WAIT_LAST   = 2'(WAIT_STATES - 1);

    typedef struct packed {
        logic [7:0] o;
        logic [7:0] oe;
    } nsio_pins_t;

    typedef struct packed {
        logic addr_strobe_n;
        logic read_write_sel;
        logic data_strobe_n;
        logic rd_strobe_n;
        logic wr_strobe_n;
    } nsio_ext_ctl_t;

    typedef enum logic [2:0] {BUS_IDLE, BUS_T1, BUS_T2, BUS_TW, BUS_T3} nsio_bus_state_t;
endpackage

// ===== design/nsio_ports.sv
// supervisor controller pin ports and external can bus master
module nsio_ports (
    input  wire logic                    mclk,
    input  wire logic                    resetn,
    input  wire logic [15:0]             cpu_addr,
    input  wire logic [7:0]              cpu_wdata,
    input  wire logic                    cpu_wr,
    input  wire logic                    cpu_rd,
    output logic [7:0]                   cpu_rdata,
    output logic                         cpu_ready,
    output logic                         cpu_busy,
    input  wire logic [11:0]             slot_position_code,
    input  wire logic                    can_irq_n_in,
    input  wire logic [15:0]             load_meter_n,
    output nsio_pkg::nsio_pins_t         port_one_pins,
    output nsio_pkg::nsio_pins_t         port_five_pins,
    output nsio_pkg::nsio_pins_t         port_six_pins,
    output nsio_pkg::nsio_ext_ctl_t      ext_ctl,
    output logic [7:0]                   ext_addr,
    output logic [7:0]                   ext_data_o,
    output logic                         ext_data_oe,
    input  wire logic [7:0]              ext_data_i
);
    import nsio_pkg::*;

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!resetn);

    logic [3:0]      div_cnt;
    logic            phi;
    logic            ph_en;
    logic [28:0]     sync_a;
    logic [28:0]     sync_b;
    logic [11:0]     sync_slot;
    logic [15:0]     sync_load;
    logic            sync_irq_n;
    logic            irq_prev;
    logic [7:0]      p1_dir;
    logic [7:0]      p1_data;
    logic [7:0]      sc1;
    logic [7:0]      p5_dir;
    logic [7:0]      p5_data;
    logic [7:0]      p6_dir;
    logic [7:0]      p6_data;
    logic [7:0]      sc2;
    logic [7:0]      bt_ctl;
    logic [7:0]      next_bt_ctl;
    logic [7:0]      xfer_data;
    logic            xfer_done;
    logic            dtc_pend;
    logic            cpu_pend;
    logic            pend_wr;
    logic [7:0]      pend_addr;
    logic [7:0]      pend_wdata;
    logic            bus_dtc;
    logic [1:0]      wait_cnt;
    nsio_bus_state_t bus_state;
    logic            is_can;
    logic            int_wr;
    logic            int_rd;
    logic            cycle_end;
    logic            strobe_on;
    logic [7:0]      p1_pin_in;
    logic [7:0]      p1_read;
    logic [7:0]      rd_mux;

    // clock phase divider; ph_en is the slow-bus tick
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            div_cnt <= 4'h0;
        end else if (div_cnt == PHI_LAST) begin
            div_cnt <= 4'h0;
        end else begin
            div_cnt <= div_cnt + 4'h1;
        end
    end
    assign phi   = (div_cnt < PHI_HALF);
    assign ph_en = (div_cnt == PHI_LAST);

    AST_PHI_RATE: assert property (ph_en |=> !ph_en [*8] ##1 !ph_en ##1 ph_en)
        else $error("slow tick not every ten clocks");
    AST_PHI_HIGH: assert property ($rose(phi) |-> ##5 $fell(phi))
        else $error("clock output high phase wrong");

    // pins arrive unrelated to mclk; only sync_b is ever looked at
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            sync_a <= '1;
            sync_b <= '1;
        end else begin
            sync_a <= {can_irq_n_in, load_meter_n, slot_position_code};
            sync_b <= sync_a;
        end
    end
    assign sync_slot  = sync_b[11:0];
    assign sync_load  = sync_b[27:12];
    assign sync_irq_n = sync_b[28];

    // stages hold all ones for two clocks after reset, so skip that span
    AST_SYNC: assert property (
        ($stable(load_meter_n) && $past(resetn, 2)) [*3] |-> sync_load == load_meter_n)
        else $error("meter synchroniser not two stages");

    // access decode; requests are refused while an external access pends
    assign is_can = (cpu_addr >= CAN_CONTROL) && (cpu_addr <= CAN_CLOCK_DIVIDER);
    assign int_wr = cpu_wr && !cpu_busy && !is_can;
    assign int_rd = cpu_rd && !cpu_wr && !cpu_busy && !is_can;

    // byte timer: illegal clear or pin clock selections are dropped
    always_comb begin
        next_bt_ctl = cpu_wdata;
        if (cpu_wdata[BT_CCLR_LSB+1] && cpu_wdata[BT_CCLR_LSB]) begin
            next_bt_ctl[BT_CCLR_LSB+1] = 1'b0;
            next_bt_ctl[BT_CCLR_LSB]   = 1'b0;
        end
        if (cpu_wdata[2:0] == BT_CKS_PIN) begin
            next_bt_ctl[2:0] = 3'h0;
        end
    end

    // port and control registers written by firmware
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            p1_dir  <= P1_DIR_RST;
            p1_data <= 8'h00;
            sc1     <= SC1_RST;
            p5_dir  <= P5_DIR_RST;
            p5_data <= 8'h00;
            p6_dir  <= P6_DIR_RST;
            p6_data <= P6_DATA_RST;
            sc2     <= 8'h00;
            bt_ctl  <= 8'h00;
        end else if (int_wr) begin
            case (cpu_addr)
                PORT_ONE_DIRECTION: p1_dir <= cpu_wdata;
                PORT_ONE_DATA: p1_data <= cpu_wdata;
                SYSTEM_CONTROL_ONE: sc1 <= cpu_wdata;
                PORT_FIVE_DIRECTION: p5_dir <= cpu_wdata;
                PORT_FIVE_DATA: p5_data <= cpu_wdata;
                PORT_SIX_DIRECTION: p6_dir <= cpu_wdata;
                PORT_SIX_DATA: p6_data <= cpu_wdata;
                // pwm and second serial selects cannot be turned on
                SYSTEM_CONTROL_TWO: sc2 <= {cpu_wdata[7:2], 2'b00};
                BYTE_TIMER_CONTROL: bt_ctl <= next_bt_ctl;
                default: ;
            endcase
        end
    end

    AST_P6_WRITE: assert property (
        int_wr && cpu_addr == PORT_SIX_DATA |=> port_six_pins.o == $past(cpu_wdata))
        else $error("port six pins do not follow data write");
    AST_SC2_PINS: assert property (sc2[SC2_PIN_FN_MSB:0] == 2'b00)
        else $error("port nine alternate function selected");
    AST_BT_CLEAR: assert property (!(bt_ctl[BT_CCLR_LSB+1] && bt_ctl[BT_CCLR_LSB]))
        else $error("byte timer pin clear enabled");

    // output pins: bit 0 of port one carries the bus clock
    assign port_one_pins.o   = {p1_data[7:1], phi};
    assign port_one_pins.oe  = p1_dir;
    assign port_five_pins.o  = p5_data;
    assign port_five_pins.oe = p5_dir;
    // bit 1 node reset, bits 2 and 3 lamps, all low active
    assign port_six_pins.o   = p6_data;
    assign port_six_pins.oe  = p6_dir;

    // irq falling edge queues a read of the can flag register
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            irq_prev <= 1'b1;
            dtc_pend <= 1'b0;
        end else begin
            irq_prev <= sync_irq_n;
            if (irq_prev && !sync_irq_n && sc1[SC1_IRQ_EN]) begin
                dtc_pend <= 1'b1;
            end else if (cycle_end && bus_dtc) begin
                dtc_pend <= 1'b0;
            end
        end
    end

    // transfer result; a new completion wins over a clear
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            xfer_data <= 8'h00;
            xfer_done <= 1'b0;
        end else if (cycle_end && bus_dtc) begin
            xfer_data <= ext_data_i;
            xfer_done <= 1'b1;
        end else if (int_wr && cpu_addr == XFER_STATUS && cpu_wdata[XFER_DONE_BIT]) begin
            xfer_done <= 1'b0;
        end
    end

    AST_IRQ_LAUNCH: assert property (
        irq_prev && !sync_irq_n && sc1[SC1_IRQ_EN] |-> ##[1:90] (bus_state == BUS_T2 && bus_dtc))
        else $error("can irq did not launch a transfer");

    // external request latch, held until its bus cycle ends
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            cpu_pend   <= 1'b0;
            pend_wr    <= 1'b0;
            pend_addr  <= 8'h00;
            pend_wdata <= 8'h00;
        end else if (!cpu_pend && is_can && (cpu_wr || cpu_rd)) begin
            cpu_pend   <= 1'b1;
            pend_wr    <= cpu_wr;
            pend_addr  <= cpu_addr[7:0];
            pend_wdata <= cpu_wdata;
        end else if (cycle_end && !bus_dtc) begin
            cpu_pend <= 1'b0;
        end
    end
    assign cpu_busy = cpu_pend;

    // bus sequencer at the slow tick; irq transfers go first
    assign cycle_end = ph_en && (bus_state == BUS_T3);
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            bus_state <= BUS_IDLE;
            bus_dtc   <= 1'b0;
            wait_cnt  <= 2'h0;
        end else if (ph_en) begin
            case (bus_state)
                BUS_IDLE: begin
                    if (dtc_pend) begin
                        bus_state <= BUS_T1;
                        bus_dtc   <= 1'b1;
                    end else if (cpu_pend) begin
                        bus_state <= BUS_T1;
                        bus_dtc   <= 1'b0;
                    end
                end
                BUS_T1: bus_state <= BUS_T2;
                BUS_T2: begin
                    bus_state <= BUS_TW;
                    wait_cnt  <= 2'h0;
                end
                BUS_TW: begin
                    if (wait_cnt == WAIT_LAST) begin
                        bus_state <= BUS_T3;
                    end else begin
                        wait_cnt <= wait_cnt + 2'h1;
                    end
                end
                BUS_T3: bus_state <= BUS_IDLE;
                default: bus_state <= BUS_IDLE;
            endcase
        end
    end

    // address and write data held in flops for the whole cycle
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            ext_addr   <= 8'h00;
            ext_data_o <= 8'h00;
        end else if (ph_en && bus_state == BUS_IDLE) begin
            ext_addr   <= dtc_pend ? CAN_IRQ_FLAGS[7:0] : pend_addr;
            ext_data_o <= pend_wdata;
        end
    end

    // strobes decode from the sequencer state
    assign strobe_on = (bus_state == BUS_T2) || (bus_state == BUS_TW) ||
                       (bus_state == BUS_T3);
    always_comb begin
        ext_ctl.addr_strobe_n  = (bus_state == BUS_IDLE);
        ext_ctl.read_write_sel = (bus_state == BUS_IDLE) || bus_dtc || !pend_wr;
        ext_ctl.data_strobe_n  = !strobe_on;
        ext_ctl.rd_strobe_n    = !(strobe_on && ext_ctl.read_write_sel);
        ext_ctl.wr_strobe_n    = !(strobe_on && !ext_ctl.read_write_sel);
    end
    // data lanes driven only while writing
    assign ext_data_oe = strobe_on && !ext_ctl.read_write_sel;

    AST_DS_WIDTH: assert property (
        $fell(ext_ctl.data_strobe_n) |-> ##39 !ext_ctl.data_strobe_n ##1 ext_ctl.data_strobe_n)
        else $error("data strobe not four slow periods");
    AST_AS_LEADS: assert property (
        $fell(ext_ctl.data_strobe_n) |-> !$past(ext_ctl.addr_strobe_n, 10))
        else $error("address strobe did not lead data strobe");
    AST_STROBE_EXCL: assert property (
        !ext_ctl.rd_strobe_n |-> ext_ctl.read_write_sel && ext_ctl.wr_strobe_n && !ext_data_oe)
        else $error("read strobe with write lane active");
    AST_CAN_WINDOW: assert property (!ext_ctl.addr_strobe_n |-> ext_addr <= CAN_SPAN_LAST)
        else $error("external access outside can window");

    COV_EXT_READ: cover property (cycle_end && !bus_dtc && !pend_wr);
    COV_EXT_WRITE: cover property (cycle_end && !bus_dtc && pend_wr);
    COV_IRQ_XFER: cover property (cycle_end && bus_dtc);
    COV_P6_WRITE: cover property (int_wr && cpu_addr == PORT_SIX_DATA);

    // port one: output bits read back as driven, inputs as synced pins
    assign p1_pin_in = {2'b00, sync_irq_n, sync_slot[11:8], 1'b0};
    assign p1_read   = (p1_dir & port_one_pins.o) | (~p1_dir & p1_pin_in);

    // read mux; unmapped addresses return zero
    always_comb begin
        case (cpu_addr)
            PORT_ONE_DIRECTION: rd_mux = p1_dir;
            PORT_ONE_DATA: rd_mux = p1_read;
            SYSTEM_CONTROL_ONE: rd_mux = sc1;
            PORT_FIVE_DIRECTION: rd_mux = p5_dir;
            PORT_FIVE_DATA: rd_mux = p5_data;
            PORT_SIX_DIRECTION: rd_mux = p6_dir;
            PORT_SIX_DATA: rd_mux = p6_data & p6_dir;
            PORT_SEVEN_DIRECTION: rd_mux = INPUT_DIR;
            PORT_SEVEN_DATA: rd_mux = sync_slot[7:0];
            PORT_EIGHT_DATA: rd_mux = sync_load[7:0];
            PORT_NINE_DIRECTION: rd_mux = INPUT_DIR;
            PORT_NINE_DATA: rd_mux = sync_load[15:8];
            SYSTEM_CONTROL_TWO: rd_mux = sc2;
            // timer and serial pin functions are hard-wired off
            TIMER_PIN_CONFIG: rd_mux = 8'h00;
            BYTE_TIMER_CONTROL: rd_mux = bt_ctl;
            // edges on these pins carry no timing; no capture kept
            TIMER1_CAPTURE: rd_mux = 8'h00;
            TIMER2_CAPTURE: rd_mux = 8'h00;
            XFER_DATA: rd_mux = xfer_data;
            XFER_STATUS: rd_mux = {7'h00, xfer_done};
            default: rd_mux = 8'h00;
        endcase
    end

    // answers: one clock for on-chip, end of bus cycle for external
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            cpu_ready <= 1'b0;
            cpu_rdata <= 8'h00;
        end else if (cycle_end && !bus_dtc) begin
            cpu_ready <= 1'b1;
            if (!pend_wr) begin
                cpu_rdata <= ext_data_i;
            end
        end else begin
            cpu_ready <= int_wr || int_rd;
            if (int_rd) begin
                cpu_rdata <= rd_mux;
            end
        end
    end

    AST_P8_READ: assert property (
        int_rd && cpu_addr == PORT_EIGHT_DATA |=> cpu_ready && cpu_rdata == $past(sync_load[7:0]))
        else $error("port eight read wrong");
endmodule // nsio_ports

// ===== verif/nsio_can_model.sv
// can controller model: 32 byte registers behind the strobed external bus
module nsio_can_model (
    input  wire logic       mclk,
    input  wire logic [7:0] ext_addr,
    input  wire logic       rd_strobe_n,
    input  wire logic       wr_strobe_n,
    input  wire logic [7:0] ext_data_o,
    output logic [7:0]      ext_data_i,
    output int              strobe_len
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] regs [32];
    logic [7:0] last;
    logic       wr_seen;
    int         cnt;

    // read-only places hold a fixed pattern that firmware cannot change
    initial begin
        for (int i = 0; i < 32; i++) begin
            regs[i] = {3'h5, 5'(i)} ^ 8'h3c;
        end
        last = 8'h00;
        wr_seen = 1'b0;
        cnt = 0;
        strobe_len = 0;
    end

    // writes land on strobe release; status, flags and receive buffer ignore them
    always @(negedge wr_strobe_n) wr_seen = 1'b1;
    always @(posedge wr_strobe_n) begin
        if (wr_seen && !(ext_addr[4:0] inside {5'h02, 5'h03, [5'h14:5'h1d]})) begin
            regs[ext_addr[4:0]] = ext_data_o;
        end
        wr_seen = 1'b0;
    end

    // released data lines show the inverse of the last byte, never a stale copy
    always @(posedge rd_strobe_n) last = regs[ext_addr[4:0]];
    assign ext_data_i = !rd_strobe_n ? regs[ext_addr[4:0]] : ~last;

    // strobe length so far, in mclk cycles; ready before the strobe lifts
    always @(posedge mclk) begin
        if (!rd_strobe_n || !wr_strobe_n) begin
            cnt++;
            strobe_len = cnt;
        end else begin
            cnt = 0;
        end
    end
endmodule // nsio_can_model

// ===== verif/test_node_supervisor_io_ports.sv
// testbench for the supervisor io ports: registers, pins and can bus traffic
module test_node_supervisor_io_ports;
    timeunit 1ns;
    timeprecision 1ps;
    import nsio_pkg::*;
    logic          mclk, resetn, cpu_wr, cpu_rd, cpu_ready, cpu_busy, can_irq_n_in, ext_data_oe;
    logic [15:0]   cpu_addr, load_meter_n;
    logic [11:0]   slot_position_code;
    logic [7:0]    cpu_wdata, cpu_rdata, ext_addr, ext_data_o, ext_data_i, snap_addr;
    nsio_pins_t    port_one_pins, port_five_pins, port_six_pins;
    nsio_ext_ctl_t ext_ctl, snap_ctl;
    logic          snap_oe;
    int            failures, checks, strobe_len;

    nsio_ports i_dut (.mclk(mclk), .resetn(resetn), .cpu_addr(cpu_addr), .cpu_wdata(cpu_wdata),
        .cpu_wr(cpu_wr), .cpu_rd(cpu_rd), .cpu_rdata(cpu_rdata), .cpu_ready(cpu_ready),
        .cpu_busy(cpu_busy), .slot_position_code(slot_position_code),
        .can_irq_n_in(can_irq_n_in), .load_meter_n(load_meter_n),
        .port_one_pins(port_one_pins), .port_five_pins(port_five_pins),
        .port_six_pins(port_six_pins), .ext_ctl(ext_ctl), .ext_addr(ext_addr),
        .ext_data_o(ext_data_o), .ext_data_oe(ext_data_oe), .ext_data_i(ext_data_i));
    nsio_can_model i_can (.mclk(mclk), .ext_addr(ext_addr), .rd_strobe_n(ext_ctl.rd_strobe_n),
        .wr_strobe_n(ext_ctl.wr_strobe_n), .ext_data_o(ext_data_o), .ext_data_i(ext_data_i),
        .strobe_len(strobe_len));

    // free-running 100 MHz clock
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end

    task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
        checks++;
        if (got !== exp) begin
            failures++;
            $display("MISMATCH %s expected %h seen %h", name, exp, got);
        end
    endtask

    // one-cycle request pulse, then a bounded wait for the answer strobe
    task automatic acc(input logic wr, input logic [15:0] a, input logic [7:0] d,
                       output logic [7:0] r);
        int n;
        @(posedge mclk) #1;
        cpu_wr = wr;
        cpu_rd = !wr;
        cpu_addr = a;
        cpu_wdata = d;
        @(posedge mclk) #1;
        cpu_wr = 1'b0;
        cpu_rd = 1'b0;
        chk("busy", {7'h0, a >= CAN_CONTROL && a <= CAN_CLOCK_DIVIDER}, {7'h0, cpu_busy});
        n = 0;
        while (cpu_ready !== 1'b1 && n < 300) begin
            if (ext_ctl.data_strobe_n === 1'b0) begin
                snap_ctl = ext_ctl;
                snap_addr = ext_addr;
                snap_oe = ext_data_oe;
            end
            @(posedge mclk) #1;
            n++;
        end
        chk("ready_seen", 8'h01, {7'h0, n < 300});
        r = cpu_rdata;
    endtask

    task automatic rd(input logic [15:0] a, input logic [7:0] exp);
        logic [7:0] r;
        acc(1'b0, a, 8'h00, r);
        chk($sformatf("reg_%h", a), exp, r);
    endtask

    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        logic [7:0] r;
        acc(1'b1, a, d, r);
    endtask

    task automatic end_sim();
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // hang guard, well beyond the several hundred cycles the sequence needs
    initial begin
        #200000;
        failures++;
        end_sim();
    end

    // main sequence
    initial begin
        logic [15:0] ra [6];
        logic [7:0]  rv [6];
        logic [7:0]  r;
        logic        prev;
        int          n;
        ra = '{16'hfe80, 16'hfe82, 16'hfe83, 16'hfe85, 16'hfe87, 16'hfe8a};
        rv = '{8'h01, 8'h20, 8'hff, 8'h0e, 8'h00, 8'h00};
        {resetn, cpu_wr, cpu_rd, cpu_addr, cpu_wdata, failures, checks} = '0;
        {can_irq_n_in, slot_position_code, load_meter_n} = {1'b1, 12'ha5c, 16'h3c96};
        repeat (6) @(posedge mclk);
        #1 resetn = 1'b1;
        // directions, system control one and pin enables out of reset
        for (int i = 0; i < 6; i++) rd(ra[i], rv[i]);
        chk("p1_oe", 8'h01, port_one_pins.oe);
        chk("p5_oe", 8'hff, port_five_pins.oe);
        chk("p5_o", 8'h00, port_five_pins.o);
        chk("p6_oe", 8'h0e, port_six_pins.oe);
        // phase clock: ten rises in a hundred mclk cycles
        prev = port_one_pins.o[0];
        n = 0;
        repeat (100) begin
            @(posedge mclk) #1;
            n += int'(port_one_pins.o[0] === 1'b1 && prev === 1'b0);
            prev = port_one_pins.o[0];
        end
        chk("phi_rises", 8'd10, 8'(n));
        // slot code and load meter reach their data registers
        rd(16'hfe88, 8'h5c);
        acc(1'b0, 16'hfe81, 8'h00, r);
        chk("p1_slot", 8'h14, r & 8'h1e);
        rd(16'hfe89, 8'h96);
        rd(16'hfe8b, 8'h3c);
        // node reset low, yellow off, green lit, then back to running
        wr(16'hfe86, 8'h04);
        chk("p6_pins", 8'h04, port_six_pins.o & 8'h0e);
        wr(16'hfe86, 8'h0e);
        chk("p6_idle", 8'h0e, port_six_pins.o & 8'h0e);
        // forbidden pin functions cannot be switched on
        wr(16'hfe8c, 8'hff);
        rd(16'hfe8c, 8'hfc);
        wr(16'hfe8e, 8'h1f);
        rd(16'hfe8e, 8'h00);
        wr(16'hfe8e, 8'h0a);
        rd(16'hfe8e, 8'h0a);
        wr(16'hfe8d, 8'hff);
        rd(16'hfe8d, 8'h00);
        rd(16'hfe8f, 8'h00);
        rd(16'hfe90, 8'h00);
        // external write and read: strobes, address, drive and two wait states
        wr(16'h8004, 8'h5a);
        chk("wr_ctl", 8'h02, {3'h0, snap_ctl});
        chk("wr_addr", 8'h04, snap_addr);
        chk("wr_oe", 8'h01, {7'h0, snap_oe});
        chk("wr_len", 8'd40, 8'(strobe_len));
        rd(16'h8004, 8'h5a);
        chk("rd_ctl", 8'h09, {3'h0, snap_ctl});
        chk("rd_len", 8'd40, 8'(strobe_len));
        wr(16'h801f, 8'hc3);
        rd(16'h801f, 8'hc3);
        wr(16'h8014, 8'h00);
        rd(16'h8014, 8'h88);
        rd(16'h8002, 8'h9e);
        // can interrupt fetches the flag register on its own
        @(posedge mclk) #1 can_irq_n_in = 1'b0;
        repeat (150) @(posedge mclk);
        acc(1'b0, 16'hfe92, 8'h00, r);
        chk("xfer_done", 8'h01, r & 8'h01);
        rd(16'hfe91, 8'h9f);
        @(posedge mclk) #1 can_irq_n_in = 1'b1;
        wr(16'hfe92, 8'h01);
        acc(1'b0, 16'hfe92, 8'h00, r);
        chk("xfer_clr", 8'h00, r & 8'h01);
        end_sim();
    end
endmodule // test_node_supervisor_io_ports
